// ==== logic/mmx_pkg.sv ====
// Package for the multiply-accumulate and maximum execution unit.
// Assumes a single 100 MHz clock and an Avalon-MM slave with byte addresses.
package mmx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on a 9-bit address bus.
  localparam logic [8:0] MMX_REG_CMD = 9'h000;
  localparam logic [8:0] MMX_REG_REPEAT = 9'h004;
  localparam logic [8:0] MMX_REG_STATUS = 9'h008;
  localparam logic [8:0] MMX_REG_MODE = 9'h00c;
  localparam logic [8:0] MMX_REG_ACC = 9'h010;
  localparam logic [8:0] MMX_REG_PROD = 9'h014;
  localparam logic [8:0] MMX_REG_MULT = 9'h018;
  localparam logic [8:0] MMX_REG_PTR = 9'h01c;
  localparam logic [8:0] MMX_REG_OFC = 9'h020;
  localparam int MMX_MEM_SEL_BIT = 8;
  localparam int MMX_ADDR_W = 9;

  // Status register bit positions.
  localparam int MMX_ST_ZERO = 0;
  localparam int MMX_ST_NEG = 1;
  localparam int MMX_ST_CARRY = 2;
  localparam int MMX_ST_OVF = 3;
  localparam int MMX_ST_BUSY = 4;

  // Mode register bit positions.
  localparam int MMX_MODE_SAT = 0;
  localparam int MMX_MODE_SHIFT_LSB = 4;

  // Widths.
  localparam int MMX_PTR_W = 22;
  localparam int MMX_OFC_W = 6;
  localparam int MMX_SHIFT_W = 4;
  localparam int MMX_MEM_DEPTH = 64;
  localparam int MMX_MEM_AW = 6;

  // Instruction encodings: command word is {first opcode word, second word}.
  localparam logic [15:0] MMX_OPC_MAC = 16'h5607;
  localparam logic [7:0] MMX_OPC_MAC_PTR = 8'hc7;
  localparam logic [7:0] MMX_OPC_MAC_INC = 8'h87;
  localparam logic [14:0] MMX_OPC_MAX = 15'h2b39;
  localparam logic [15:0] MMX_OPC_MAXC = 16'h5651;
  localparam logic [7:0] MMX_OPC_EXT_ZERO = 8'h00;

  // Operand field: mode in bits 7:6, direct word address in bits 5:0.
  localparam logic [1:0] MMX_AM_DIRECT = 2'h0;
  localparam logic [1:0] MMX_AM_PTR = 2'h1;
  localparam logic [1:0] MMX_AM_PTR_INC = 2'h2;
  localparam logic [1:0] MMX_AM_PTR_DEC = 2'h3;

  // Saturation limits.
  localparam logic [31:0] MMX_SAT_POS = 32'h7fffffff;
  localparam logic [31:0] MMX_SAT_NEG = 32'h80000000;

  // Reset values.
  localparam logic [31:0] MMX_RST_WORD = 32'h00000000;

  typedef enum logic [0:0] {MMX_IDLE = 1'b0, MMX_EXEC = 1'b1} mmx_fsm_t;
  typedef enum logic [1:0] {MMX_OP_MAC = 2'b00, MMX_OP_MAX = 2'b01, MMX_OP_MAXC = 2'b10} mmx_op_t;

  // Arithmetic flags carried together.
  typedef struct packed {
    logic ovf;
    logic carry;
    logic neg;
    logic zero;
  } mmx_flags_t;

  // Whole state of the execution unit.
  typedef struct packed {
    mmx_fsm_t fsm;
    mmx_op_t op;
    logic waitreq;
    logic [31:0] rdata;
    logic [31:0] cmd;
    logic [31:0] acc;
    logic [31:0] prod;
    logic [15:0] mult;
    logic [MMX_PTR_W-1:0] ptr;
    logic [MMX_OFC_W-1:0] ofc;
    logic [15:0] rep;
    mmx_flags_t flags;
    logic sat;
    logic [MMX_SHIFT_W-1:0] pshift;
    logic [MMX_MEM_DEPTH-1:0][15:0] mem;
  } mmx_state_t;

endpackage : mmx_pkg

// ==== logic/mmx_exec_unit.sv ====
// Execution unit for the pointer multiply-accumulate, signed 16-bit maximum
// and flag-conditioned unsigned maximum, with a unified operand memory.
// Assumes an Avalon-MM master with waitrequest and one 100 MHz clock.
`timescale 1ns/1ps

// Functional notes
// - MAC adds shifted old product to accumulator, loads multiplicand, multiplies by coefficient.
// - Coefficient reads through the pointer use the same memory array as data reads.
// - Pointer change requested by the data operand field beats the coefficient post-increment.
// - After MAC addition, zero flag shows whether the accumulator equals zero.
// - After MAC addition, negative flag copies accumulator bit 31.
// - Carry flag takes the carry out of the MAC addition.
// - Overflow flag is set on MAC overflow and otherwise kept.
// - Without saturation, overflow counter counts up on positive, down on negative overflow.
// - With saturation, an overflowing MAC clamps to the largest positive or negative value.
// - Product shift: left shifts zero-fill, right shifts sign-extend.
// - Repeated MAC runs count plus one times; overflow flag remembers any overflow.
// - Signed maximum on chosen accumulator half loads operand when half is smaller.
// - Signed maximum sets negative flag exactly when the half is smaller.
// - Signed maximum sets zero flag exactly when half equals operand.
// - Signed maximum sets overflow flag when half is smaller, never clears it.
// - Repeated signed maximum runs count plus one times; negative and zero flags show the last pass.
// - Conditional maximum loads product when negative set and zero clear; keeps it when both clear.
// - Conditional maximum compares product and operand as unsigned 32-bit values.
// - With zero set, negative clear and product smaller, load product and set overflow.
// - Conditional maximum never repeats; it clears the repeat counter and runs once.
module mmx_exec_unit
  import mmx_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic [MMX_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [1:0] rst_sync;
  logic rst_n;
  mmx_state_t st;
  mmx_state_t next_st;

  logic [1:0] am_mode;
  logic [MMX_MEM_AW-1:0] data_addr;
  logic [MMX_MEM_AW-1:0] data_addr_hi;
  logic [MMX_PTR_W-1:0] ptr_inc;
  logic [MMX_PTR_W-1:0] ptr_dec;
  logic [MMX_PTR_W-1:0] mac_ptr;
  logic [15:0] op16;
  logic [31:0] op32;
  logic [15:0] coef;
  logic [31:0] prod_shifted;
  logic [32:0] sum33;
  logic ovf_pos;
  logic ovf_neg;
  logic [31:0] mac_acc;
  logic [31:0] mac_prod;
  logic [15:0] max_half;
  logic max_lt;
  logic max_eq;
  logic maxc_lt;
  logic [31:0] reg_rdata;
  logic bus_req;
  logic [MMX_MEM_AW-1:0] bus_word;
  logic cmd_legal;
  mmx_op_t cmd_op;

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Shifts the product by a signed amount, zero fill left, sign fill right.
  function automatic logic [31:0] shift_prod(input logic [31:0] p, input logic [MMX_SHIFT_W-1:0] amt);
    logic [MMX_SHIFT_W-1:0] mag;
    mag = -amt;
    if (amt[MMX_SHIFT_W-1])
    begin
      shift_prod = 32'($signed(p) >>> mag);
    end
    else
    begin
      shift_prod = p << amt;
    end
  endfunction : shift_prod

  // Merges write data into an old word under the byte enables.
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    be_merge = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        be_merge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction : be_merge

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_sync <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Operand addressing into the shared memory array.
  assign am_mode = st.cmd[7:6];
  assign ptr_inc = st.ptr + 22'h000001;
  assign ptr_dec = st.ptr - 22'h000001;
  always_comb
  begin
    unique case (am_mode)
      MMX_AM_DIRECT: data_addr = st.cmd[MMX_MEM_AW-1:0];
      MMX_AM_PTR, MMX_AM_PTR_INC: data_addr = st.ptr[MMX_MEM_AW-1:0];
      MMX_AM_PTR_DEC: data_addr = ptr_dec[MMX_MEM_AW-1:0];
    endcase
  end
  assign data_addr_hi = data_addr + 6'h01;
  assign op16 = st.mem[data_addr];
  assign op32 = {st.mem[data_addr_hi], st.mem[data_addr]};
  assign coef = st.mem[st.ptr[MMX_MEM_AW-1:0]];

  // Final pointer after a MAC pass; the data operand's change wins.
  always_comb
  begin
    if (am_mode == MMX_AM_PTR_INC)
    begin
      mac_ptr = ptr_inc;
    end
    else if (am_mode == MMX_AM_PTR_DEC)
    begin
      mac_ptr = ptr_dec;
    end
    else if (st.cmd[15:8] == MMX_OPC_MAC_INC)
    begin
      mac_ptr = ptr_inc;
    end
    else
    begin
      mac_ptr = st.ptr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multiply-accumulate datapath for one pass.
  assign prod_shifted = shift_prod(st.prod, st.pshift);
  assign sum33 = {1'b0, st.acc} + {1'b0, prod_shifted};
  assign ovf_pos = !st.acc[31] && !prod_shifted[31] && sum33[31];
  assign ovf_neg = st.acc[31] && prod_shifted[31] && !sum33[31];
  always_comb
  begin
    if (st.sat && ovf_pos)
    begin
      mac_acc = MMX_SAT_POS;
    end
    else if (st.sat && ovf_neg)
    begin
      mac_acc = MMX_SAT_NEG;
    end
    else
    begin
      mac_acc = sum33[31:0];
    end
  end
  assign mac_prod = 32'($signed(op16) * $signed(coef));

  // Signed and unsigned comparisons for the maximum operations.
  assign max_half = st.cmd[16] ? st.acc[31:16] : st.acc[15:0];
  assign max_lt = $signed(max_half) < $signed(op16);
  assign max_eq = max_half == op16;
  assign maxc_lt = st.prod < op32;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and read multiplexer.
  assign bus_req = avs_read_i || avs_write_i;
  assign bus_word = avs_address_i[MMX_MEM_AW+1:2];
  always_comb
  begin
    reg_rdata = MMX_RST_WORD;
    if (avs_address_i[MMX_MEM_SEL_BIT])
    begin
      reg_rdata = {16'h0000, st.mem[bus_word]};
    end
    else
    begin
      unique case (avs_address_i)
        MMX_REG_CMD: reg_rdata = st.cmd;
        MMX_REG_REPEAT: reg_rdata = {16'h0000, st.rep};
        MMX_REG_STATUS: reg_rdata = {27'h0000000, st.fsm == MMX_EXEC, st.flags.ovf, st.flags.carry,
                                     st.flags.neg, st.flags.zero};
        MMX_REG_MODE: reg_rdata = {24'h000000, st.pshift, 3'h0, st.sat};
        MMX_REG_ACC: reg_rdata = st.acc;
        MMX_REG_PROD: reg_rdata = st.prod;
        MMX_REG_MULT: reg_rdata = {16'h0000, st.mult};
        MMX_REG_PTR: reg_rdata = {10'h000, st.ptr};
        MMX_REG_OFC: reg_rdata = {26'h0000000, st.ofc};
        default: reg_rdata = MMX_RST_WORD;
      endcase
    end
  end

  // Command decode of the first and second opcode words.
  always_comb
  begin
    cmd_legal = 1'b1;
    cmd_op = MMX_OP_MAC;
    if (avs_writedata_i[31:16] == MMX_OPC_MAC &&
        (avs_writedata_i[15:8] == MMX_OPC_MAC_PTR || avs_writedata_i[15:8] == MMX_OPC_MAC_INC))
    begin
      cmd_op = MMX_OP_MAC;
    end
    else if (avs_writedata_i[31:17] == MMX_OPC_MAX && avs_writedata_i[15:8] == MMX_OPC_EXT_ZERO)
    begin
      cmd_op = MMX_OP_MAX;
    end
    else if (avs_writedata_i[31:16] == MMX_OPC_MAXC && avs_writedata_i[15:8] == MMX_OPC_EXT_ZERO)
    begin
      cmd_op = MMX_OP_MAXC;
    end
    else
    begin
      cmd_legal = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus slave while idle, one pass per cycle while busy.
  always_comb
  begin
    next_st = st;
    // Accesses are stalled by waitrequest while an instruction runs.
    if (!st.waitreq)
    begin
      next_st.waitreq = 1'b1;
    end
    else if (bus_req && st.fsm == MMX_IDLE)
    begin
      next_st.waitreq = 1'b0;
      next_st.rdata = reg_rdata;
      if (avs_write_i && avs_address_i[MMX_MEM_SEL_BIT])
      begin
        next_st.mem[bus_word] = 16'(be_merge({16'h0000, st.mem[bus_word]}, avs_writedata_i, avs_byteenable_i));
      end
      else if (avs_write_i)
      begin
        unique case (avs_address_i)
          MMX_REG_CMD:
          begin
            if (cmd_legal)
            begin
              next_st.cmd = avs_writedata_i;
              next_st.op = cmd_op;
              next_st.fsm = MMX_EXEC;
              if (cmd_op == MMX_OP_MAXC)
              begin
                next_st.rep = 16'h0000;
              end
            end
          end
          MMX_REG_REPEAT: next_st.rep = 16'(be_merge({16'h0000, st.rep}, avs_writedata_i, avs_byteenable_i));
          MMX_REG_STATUS:
          begin
            if (avs_byteenable_i[0])
            begin
              next_st.flags = avs_writedata_i[MMX_ST_OVF:MMX_ST_ZERO];
            end
          end
          MMX_REG_MODE:
          begin
            if (avs_byteenable_i[0])
            begin
              next_st.sat = avs_writedata_i[MMX_MODE_SAT];
              next_st.pshift = avs_writedata_i[MMX_MODE_SHIFT_LSB +: MMX_SHIFT_W];
            end
          end
          MMX_REG_ACC: next_st.acc = be_merge(st.acc, avs_writedata_i, avs_byteenable_i);
          MMX_REG_PROD: next_st.prod = be_merge(st.prod, avs_writedata_i, avs_byteenable_i);
          MMX_REG_MULT: next_st.mult = 16'(be_merge({16'h0000, st.mult}, avs_writedata_i, avs_byteenable_i));
          MMX_REG_PTR: next_st.ptr = MMX_PTR_W'(be_merge({10'h000, st.ptr}, avs_writedata_i,
                                              avs_byteenable_i));
          MMX_REG_OFC: next_st.ofc = MMX_OFC_W'(be_merge({26'h0000000, st.ofc}, avs_writedata_i,
                                              avs_byteenable_i));
          default: next_st.rdata = MMX_RST_WORD;
        endcase
      end
    end

    // One instruction pass per clock while executing.
    if (st.fsm == MMX_EXEC)
    begin
      unique case (st.op)
        MMX_OP_MAC:
        begin
          next_st.acc = mac_acc;
          next_st.mult = op16;
          next_st.prod = mac_prod;
          next_st.ptr = mac_ptr;
          next_st.flags.zero = mac_acc == 32'h00000000;
          next_st.flags.neg = mac_acc[31];
          next_st.flags.carry = sum33[32];
          next_st.flags.ovf = st.flags.ovf || ovf_pos || ovf_neg;
          if (!st.sat && ovf_pos)
          begin
            next_st.ofc = st.ofc + 6'h01;
          end
          else if (!st.sat && ovf_neg)
          begin
            next_st.ofc = st.ofc - 6'h01;
          end
        end
        MMX_OP_MAX:
        begin
          if (max_lt && st.cmd[16])
          begin
            next_st.acc[31:16] = op16;
          end
          else if (max_lt)
          begin
            next_st.acc[15:0] = op16;
          end
          next_st.flags.neg = max_lt;
          next_st.flags.zero = max_eq;
          next_st.flags.ovf = st.flags.ovf || max_lt;
        end
        MMX_OP_MAXC:
        begin
          if (st.flags.neg && !st.flags.zero)
          begin
            next_st.prod = op32;
          end
          else if (!st.flags.neg && st.flags.zero && maxc_lt)
          begin
            next_st.prod = op32;
            next_st.flags.ovf = 1'b1;
          end
          else
          begin
            next_st.prod = st.prod;
          end
        end
        default: next_st.fsm = MMX_IDLE;
      endcase
      // Count passes down; the last pass returns to idle.
      if (st.rep == 16'h0000)
      begin
        next_st.fsm = MMX_IDLE;
      end
      else
      begin
        next_st.rep = st.rep - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, frozen while the clock enable is low.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.waitreq <= 1'b1;
    end
    else if (clk_en_i)
    begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state flip-flops.
  assign avs_readdata_o = st.rdata;
  assign avs_waitrequest_o = st.waitreq;
  assign busy_o = st.fsm[0];

endmodule : mmx_exec_unit

// ==== sim/mmx_exec_chk.sv ====
// Checker for the execution unit: bus handshake, busy length and read-back values.
// Assumes it is bound to mmx_exec_unit and sees only that module's ports.
`timescale 1ns/1ps
module mmx_exec_chk
  import mmx_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic [MMX_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic busy_o
);
  logic take;
  logic legal;
  logic [15:0] rep;
  logic [16:0] want;
  logic [16:0] cnt;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // An access is taken when the slave is idle; a command word is legal when its opcode fits.
  assign take = (avs_read_i | avs_write_i) & avs_waitrequest_o & !busy_o & clk_en_i;
  assign legal = (avs_writedata_i[31:16] == MMX_OPC_MAC) ? ((avs_writedata_i[15:8] == MMX_OPC_MAC_PTR) |
    (avs_writedata_i[15:8] == MMX_OPC_MAC_INC)) :
    (((avs_writedata_i[31:17] == MMX_OPC_MAX) | (avs_writedata_i[31:16] == MMX_OPC_MAXC))
    & (avs_writedata_i[15:8] == MMX_OPC_EXT_ZERO));
  // Shadow of the repeat count, the busy length it implies, and the running busy length.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rep <= '0;
      want <= '0;
      cnt <= '0;
    end
    else
    begin
      if (busy_o)
        rep <= '0;
      else if (take & avs_write_i & (avs_address_i == MMX_REG_REPEAT))
        rep <= avs_writedata_i[15:0];
      if (take & avs_write_i & (avs_address_i == MMX_REG_CMD))
        want <= (avs_writedata_i[31:16] == MMX_OPC_MAXC) ? 17'h1 : {1'b0, rep} + 17'h1;
      cnt <= busy_o ? cnt + 17'h1 : 17'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Handshake, execution length and read values.
  a_ack_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest stayed low for more than one cycle");
  a_reg_answer: assert property (take && !(avs_write_i && avs_address_i == MMX_REG_CMD) |=> !avs_waitrequest_o)
    else $error("register access not answered in the next cycle");
  a_cmd_busy: assert property (take && avs_write_i && avs_address_i == MMX_REG_CMD && legal
    |=> busy_o)
    else $error("legal command did not start execution");
  a_busy_length: assert property ($fell(busy_o) |-> cnt == want)
    else $error("execution length differs from repeat count");
  a_repeat_value: assert property (take && avs_read_i && avs_address_i == MMX_REG_REPEAT
    |=> avs_readdata_o == {16'h0, rep})
    else $error("repeat count read back wrong");
  a_unmapped_zero: assert property (take && avs_read_i && !avs_address_i[MMX_MEM_SEL_BIT] && avs_address_i > MMX_REG_OFC
    |=> avs_readdata_o == 32'h0)
    else $error("unmapped register read not zero");
  a_mem_upper: assert property (take && avs_read_i && avs_address_i[MMX_MEM_SEL_BIT]
    |=> avs_readdata_o[31:16] == 16'h0)
    else $error("memory word upper half not zero");
  a_status_idle: assert property (take && avs_read_i && avs_address_i == MMX_REG_STATUS |=> avs_readdata_o[31:4] == 28'h0)
    else $error("status upper bits or busy bit set on idle read");
  a_read_hold: assert property (!take |=> $stable(avs_readdata_o))
    else $error("read data changed without an accepted access");
  c_maxc_cmd: cover property (take && avs_write_i && avs_address_i == MMX_REG_CMD && avs_writedata_i[31:16] == MMX_OPC_MAXC);
  c_long_busy: cover property ($fell(busy_o) && cnt > 17'h2);
  c_unmapped: cover property (take && avs_read_i && avs_address_i == 9'h024);
endmodule : mmx_exec_chk

bind mmx_exec_unit mmx_exec_chk u_chk (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .busy_o(busy_o)
);

// ==== sim/mmx_host_model.sv ====
// Bus master model standing in for the instruction decoder on the register bus.
// Assumes one clock; callers run transfers one after another from one process.
`timescale 1ns/1ps
module mmx_host_model
  import mmx_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic avs_waitrequest_i,
  output logic [MMX_ADDR_W-1:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o
);
  // Idle bus from time zero.
  initial
  begin
    avs_address_o = '0;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = '0;
    avs_byteenable_o = 4'hf;
  end
  // One transfer, held until waitrequest is sampled low; released data is inverted so stale values are not mistaken.
  task automatic xfer(input logic wr, input logic [MMX_ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge sys_clk_i);
    avs_address_o <= a;
    avs_read_o <= !wr;
    avs_write_o <= wr;
    avs_writedata_o <= d;
    avs_byteenable_o <= be;
    do
      @(posedge sys_clk_i);
    while (avs_waitrequest_i !== 1'b0);
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    avs_writedata_o <= ~d;
  endtask : xfer
endmodule : mmx_host_model

// ==== sim/tb.sv ====
// Self-checking bench for the execution unit: registers, memory, MAC, MAX and conditional maximum.
// Assumes the checker is bound from its own file and the host model drives the bus.
`timescale 1ns/1ps
module tb;
  import mmx_pkg::*;
  logic sys_clk_i;
  logic arst_n_i;
  logic clk_en_i;
  logic [MMX_ADDR_W-1:0] addr;
  logic rd_en;
  logic wr_en;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic waitreq;
  logic busy;
  int mismatches = 0;
  int tests_run = 0;
  int seed;
  logic [31:0] exp_q[$];
  string name_q[$];
  logic [31:0] m_acc = '0;
  logic [31:0] m_prod = '0;
  logic [15:0] m_mult = '0;
  logic [21:0] m_ptr = '0;
  logic [5:0] m_ofc = '0;
  logic [15:0] m_rep = '0;
  logic [3:0] m_shift = '0;
  logic m_sat = 1'b0;
  mmx_flags_t m_f = '0;
  logic [15:0] mem[64];

  mmx_host_model u_host (
    .sys_clk_i(sys_clk_i), .avs_waitrequest_i(waitreq), .avs_address_o(addr), .avs_read_o(rd_en),
    .avs_write_o(wr_en), .avs_writedata_o(wdata), .avs_byteenable_o(be)
  );
  mmx_exec_unit u_dut (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i), .avs_address_i(addr),
    .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .busy_o(busy)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
    end
  endtask : check
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // Bus shorthands; a read notes its expectation before it is issued.
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, 4'hf);
  endtask : wr
  task automatic rd(input logic [8:0] a, input logic [31:0] want, input string nm);
    exp_q.push_back(want);
    name_q.push_back(nm);
    u_host.xfer(1'b0, a, 32'h0, 4'hf);
  endtask : rd
  // Reads every visible register except the command and mode registers against the shadow state.
  task automatic read_all();
    rd(MMX_REG_ACC, m_acc, "accumulator");
    rd(MMX_REG_PROD, m_prod, "product");
    rd(MMX_REG_MULT, {16'h0, m_mult}, "multiplicand");
    rd(MMX_REG_PTR, {10'h0, m_ptr}, "pointer");
    rd(MMX_REG_STATUS, {28'h0, m_f}, "status");
    rd(MMX_REG_OFC, {26'h0, m_ofc}, "overflow counter");
    rd(MMX_REG_REPEAT, 32'h0, "repeat count");
  endtask : read_all
  // Works one instruction through the shadow state, then issues its command word.
  task automatic run_op(input int op, input logic [7:0] fld, input logic sel);
    logic [31:0] sp;
    logic [32:0] sum;
    logic signed [31:0] pr;
    logic [31:0] w;
    logic [21:0] dp;
    logic [15:0] h;
    logic [15:0] d;
    logic ov;
    int s;
    int n;
    n = (op == 2) ? 0 : int'(m_rep);
    for (int i = 0; i <= n; i++)
    begin
      if (op == 0)
      begin
        s = int'($signed(m_shift));
        if (s >= 0)
          sp = m_prod << s;
        else
          sp = $signed(m_prod) >>> (-s);
        sum = {1'b0, m_acc} + {1'b0, sp};
        ov = (m_acc[31] == sp[31]) && (sum[31] != m_acc[31]);
        m_f.carry = sum[32];
        m_f.ovf = m_f.ovf | ov;
        if (ov && !m_sat)
          m_ofc = m_acc[31] ? m_ofc - 6'h1 : m_ofc + 6'h1;
        m_acc = (ov && m_sat) ? (m_acc[31] ? MMX_SAT_NEG : MMX_SAT_POS) : sum[31:0];
        m_f.zero = (m_acc == 32'h0);
        m_f.neg = m_acc[31];
        dp = (fld[7:6] == MMX_AM_PTR_DEC) ? m_ptr - 22'h1 : m_ptr;
        m_mult = mem[(fld[7:6] == MMX_AM_DIRECT) ? fld[5:0] : dp[5:0]];
        pr = $signed(m_mult) * $signed(mem[m_ptr[5:0]]);
        m_prod = pr;
        if (fld[7:6] == MMX_AM_PTR_DEC)
          m_ptr = dp;
        else if (fld[7:6] == MMX_AM_PTR_INC || sel)
          m_ptr = m_ptr + 22'h1;
      end
      else if (op == 1)
      begin
        h = sel ? m_acc[31:16] : m_acc[15:0];
        d = mem[fld[5:0]];
        m_f.neg = ($signed(h) < $signed(d));
        m_f.zero = (h == d);
        m_f.ovf = m_f.ovf | m_f.neg;
        if (m_f.neg && sel)
          m_acc[31:16] = d;
        if (m_f.neg && !sel)
          m_acc[15:0] = d;
      end
      else
      begin
        w = {mem[fld[5:0] + 6'h1], mem[fld[5:0]]};
        if (m_f.neg && !m_f.zero)
          m_prod = w;
        else if (!m_f.neg && m_f.zero && m_prod < w)
        begin
          m_prod = w;
          m_f.ovf = 1'b1;
        end
      end
    end
    m_rep = 16'h0;
    wr(MMX_REG_CMD, (op == 0) ? {MMX_OPC_MAC, sel ? MMX_OPC_MAC_INC : MMX_OPC_MAC_PTR, fld}
      : (op == 1) ? {MMX_OPC_MAX, sel, MMX_OPC_EXT_ZERO, fld} : {MMX_OPC_MAXC, MMX_OPC_EXT_ZERO, fld});
  endtask : run_op
  ////////////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz.
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // Takes the oldest expectation whenever the slave answers a read.
  always @(posedge sys_clk_i)
  begin
    if (rd_en === 1'b1 && waitreq === 1'b0 && exp_q.size() > 0)
      check(name_q.pop_front(), rdata, exp_q.pop_front());
  end
  // Cuts a hang short well beyond the expected length of the run.
  initial
  begin
    repeat (40000) @(posedge sys_clk_i);
    mismatches++;
    summarize();
  end
  // Main sequence: reset values, memory, random instructions, lanes and unmapped writes.
  initial
  begin
    int op;
    logic [7:0] fld;
    logic sel;
    logic [31:0] v;
    seed = 32'h1d2a7531;
    clk_en_i = 1'b1;
    arst_n_i = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    for (int a = 0; a <= 36; a += 4)
      rd(9'(a), 32'h0, "reset value");
    for (int i = 0; i < 64; i++)
    begin
      mem[i] = 16'($random(seed));
      wr({1'b1, 6'(i), 2'h0}, {16'($random(seed)), mem[i]});
      rd({1'b1, 6'(i), 2'h0}, {16'h0, mem[i]}, "memory word");
    end
    repeat (90)
    begin
      op = ($random(seed) & 3) % 3;
      fld = 8'($random(seed));
      if (op != 0)
        fld[7:6] = MMX_AM_DIRECT;
      sel = 1'($random(seed));
      m_acc = $random(seed);
      m_prod = $random(seed);
      m_ptr = 22'($random(seed));
      m_f = 4'($random(seed));
      m_sat = 1'($random(seed));
      m_shift = 4'($random(seed));
      m_rep = 16'($random(seed) & 3);
      wr(MMX_REG_ACC, m_acc);
      wr(MMX_REG_PROD, m_prod);
      wr(MMX_REG_PTR, {10'h0, m_ptr});
      wr(MMX_REG_STATUS, {28'($random(seed)), m_f});
      wr(MMX_REG_MODE, {24'h0, m_shift, 3'h0, m_sat});
      wr(MMX_REG_REPEAT, {16'h0, m_rep});
      run_op(op, fld, sel);
      read_all();
    end
    v = $random(seed);
    u_host.xfer(1'b1, MMX_REG_ACC, v, 4'h3);
    m_acc[15:0] = v[15:0];
    rd(MMX_REG_ACC, m_acc, "accumulator lanes");
    wr(9'h030, v);
    rd(9'h030, 32'h0, "unmapped register");
    @(posedge sys_clk_i);
    summarize();
  end
endmodule : tb
